// ===== rtl/ifpc_flash_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "ifpc_regs.vh"
// Notes on behaviour
// RQ1: Page erase clears 64 words, upper address bits
// RQ2: Write programs a 64-word block
// RQ3: Read returns exactly one 16-bit word
// RQ4: Registers at 43H-4FH, sector high byte 01H
// RQ5: Software reaches registers through paired pointers
// RQ6: Clearing write-enabled status disables flash writes
// RQ7: Software writing 1 to status does nothing
// RQ8: Status set only after successful unlock sequence
// RQ9: Mode codes: write, erase, read, unlock
// RQ10: Enable bit plus unlock mode runs unlock
// RQ11: No re-unlock needed for later operations
// RQ12: Software sets write start, hardware clears
// RQ13: Software sets read start, hardware clears
// RQ14: Read-enable bit gates flash reads
// RQ15: Serial programming: shared data line, separate clock
// RQ16: Debug pins still serve as programming pins
// RQ17: Write and erase ignored while not enabled
// RQ18: Data0 high write loads buffer, bumps address
// RQ19: Six-byte pattern within timeout, else fails
// RQ20: Writing 55H to reset key resets chip
// RQ21: Buffer clear bit self-clears when done
module ifpc_flash_seq (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Data memory register port
   input wire [7:0] bus_sector_i,
   input wire [7:0] bus_addr_i,
   input wire bus_wr_i,
   input wire bus_rd_i,
   input wire [7:0] bus_wdata_i,
   output reg [7:0] bus_rdata_o,
   // Flash array port
   output reg fl_req_o,
   output reg [1:0] fl_op_o,
   output reg [14:0] fl_addr_o,
   output reg [15:0] fl_wdata_o,
   input wire fl_ack_i,
   input wire [15:0] fl_rdata_i,
   // Sub clock for the unlock timeout
   input wire sub_clk_i,
   // System effects
   output reg cpu_hold_o,
   output reg chip_rst_o,
   // Shared programming / debug pads
   input wire prog_serial_data_i,
   output reg prog_serial_data_o,
   output reg prog_serial_data_oe_o,
   input wire prog_serial_clock_i,
   // Programming engine side
   output reg icp_data_o,
   output reg icp_clock_o,
   input wire icp_tx_data_i,
   input wire icp_tx_en_i
);
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ERASE = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_READ = 3'h3;
   localparam [2:0] ST_CLEAR = 3'h4;
   // Unlock pattern byte for a given step
   function [7:0] pat_byte;
      input [2:0] step;
      begin
         case (step)
            3'h0: pat_byte = `IFPC_PAT0;
            3'h1: pat_byte = `IFPC_PAT1;
            3'h2: pat_byte = `IFPC_PAT2;
            3'h3: pat_byte = `IFPC_PAT3;
            3'h4: pat_byte = `IFPC_PAT4;
            default: pat_byte = `IFPC_PAT5;
         endcase
      end
   endfunction
   // Register write strobe for one address
   function wr_hit;
      input [7:0] a;
      begin
         wr_hit = bus_wr_i && (bus_sector_i == `IFPC_SECTOR) && (bus_addr_i == a);
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Register state
   reg wen_r; // Write-enabled status
   reg [2:0] mode_r; // Operation select
   reg unlk_r; // Unlock procedure enable
   reg wt_r; // Write start
   reg rden_r; // Read enable
   reg rd_r; // Read start
   reg buffer_clear_start_r; // Buffer clear start
   reg [7:0] key_r; // Chip reset key
   reg [14:0] far_r; // Flash address pair
   reg [7:0] fd_r [0:7]; // Data register pairs
   reg [15:0] wbuf_r [0:`IFPC_PAGE_WORDS-1]; // Write buffer
   reg [2:0] st_r; // Sequencer state
   reg [5:0] idx_r; // Word index in page
   reg [8:0] page_r; // Page latched at start
   reg [2:0] pat_r; // Unlock pattern step
   reg [4:0] tmo_r; // Unlock timeout count
   reg sub_s1_r, sub_s2_r, sub_s3_r; // Sub clock synchroniser
   reg sub_lvl_r, sub_prev_r; // Filtered sub clock and its last value
   reg sda_s1_r, sda_s2_r, sda_s3_r; // Pad data synchroniser
   reg sck_s1_r, sck_s2_r, sck_s3_r; // Pad clock synchroniser
   ////////////////////////////////////////////////////////////////////////////
   // Decodes
   wire in_range = (bus_sector_i == `IFPC_SECTOR) && (bus_addr_i >= `IFPC_ADDR_FIRST)
                   && (bus_addr_i <= `IFPC_ADDR_LAST); // RQ4
   wire fd_wr = bus_wr_i && in_range && (bus_addr_i >= `IFPC_ADDR_DATA0);
   wire [7:0] fd_off = bus_addr_i - `IFPC_ADDR_DATA0;
   wire [2:0] fd_idx = fd_off[2:0];
   wire ctrl_wr = wr_hit(`IFPC_ADDR_CTRL);
   wire [2:0] new_mode = bus_wdata_i[`IFPC_B_MODE_HI:`IFPC_B_MODE_LO];
   wire unlk_act = unlk_r && (mode_r == `IFPC_OP_UNLOCK); // RQ10
   wire sub_tick = sub_lvl_r && !sub_prev_r;
   wire pat_wr = unlk_act && fd_wr && (fd_idx >= `IFPC_PAT_BASE);
   wire pat_ok = (fd_idx == pat_r + `IFPC_PAT_BASE) && (bus_wdata_i == pat_byte(pat_r));
   wire unlk_pass = pat_wr && pat_ok && (pat_r == `IFPC_PAT_LAST);
   wire unlk_fail = unlk_act && ((pat_wr && !pat_ok) || (tmo_r >= `IFPC_UNLOCK_TICKS)); // RQ19
   wire last_ack = fl_ack_i && (idx_r == `IFPC_IDX_LAST);
   wire clr_done = (st_r == ST_CLEAR) && (idx_r == `IFPC_IDX_LAST);
   ////////////////////////////////////////////////////////////////////////////
   // Sub clock sync: three flops, change taken when second and third agree
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         sub_s1_r <= 1'b0;
         sub_s2_r <= 1'b0;
         sub_s3_r <= 1'b0;
         sub_lvl_r <= 1'b0;
         sub_prev_r <= 1'b0;
      end else begin
         sub_s1_r <= sub_clk_i;
         sub_s2_r <= sub_s1_r;
         sub_s3_r <= sub_s2_r;
         if (sub_s2_r == sub_s3_r) begin
            sub_lvl_r <= sub_s3_r;
         end
         sub_prev_r <= sub_lvl_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Programming pads: one bidirectional data line plus clock line
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         sda_s1_r <= 1'b0;
         sda_s2_r <= 1'b0;
         sda_s3_r <= 1'b0;
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_s3_r <= 1'b0;
         icp_data_o <= 1'b0;
         icp_clock_o <= 1'b0;
         prog_serial_data_o <= 1'b0;
         prog_serial_data_oe_o <= 1'b0;
      end else begin
         sda_s1_r <= prog_serial_data_i;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
         sck_s1_r <= prog_serial_clock_i;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         if (sda_s2_r == sda_s3_r) begin // Same pads on every variant
            icp_data_o <= sda_s3_r; // RQ15 RQ16
         end
         if (sck_s2_r == sck_s3_r) begin
            icp_clock_o <= sck_s3_r; // RQ15 RQ16
         end
         prog_serial_data_o <= icp_tx_data_i; // RQ15
         prog_serial_data_oe_o <= icp_tx_en_i; // Engine drives the shared line back out
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Address, data, key and write buffer registers
   always @(posedge clk_i) begin : data_regs
      integer i;
      if (!nrst_i) begin
         key_r <= `IFPC_BYTE_RST;
         far_r <= 15'h0000;
         chip_rst_o <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            fd_r[i] <= `IFPC_BYTE_RST;
         end
      end else begin
         chip_rst_o <= 1'b0;
         if (wr_hit(`IFPC_ADDR_RSTKEY)) begin // Magic value fires a one-cycle chip reset
            key_r <= bus_wdata_i;
            chip_rst_o <= (bus_wdata_i == `IFPC_CHIP_RST_KEY); // RQ20
         end
         if (wr_hit(`IFPC_ADDR_FLASH_ADDR_LOW)) begin
            far_r[7:0] <= bus_wdata_i;
         end
         if (wr_hit(`IFPC_ADDR_FLASH_ADDR_HIGH)) begin
            far_r[14:8] <= bus_wdata_i[6:0];
         end
         if (fd_wr) begin
            fd_r[fd_idx] <= bus_wdata_i;
         end
         if (fd_wr && (fd_idx == 3'h1)) begin // Data0 high: word to buffer, address steps on
            far_r <= far_r + 15'h0001; // RQ18
         end
         if ((st_r == ST_READ) && fl_ack_i) begin // Read result lands in data pair 0
            fd_r[0] <= fl_rdata_i[7:0]; // RQ3
            fd_r[1] <= fl_rdata_i[15:8]; // RQ3
         end
      end
   end
   // Write buffer: loaded from data0, wiped by the clear sequence
   always @(posedge clk_i) begin
      if (fd_wr && (fd_idx == 3'h1)) begin
         wbuf_r[far_r[5:0]] <= {bus_wdata_i, fd_r[0]}; // RQ18
      end else if (st_r == ST_CLEAR) begin
         wbuf_r[idx_r] <= 16'h0000; // RQ21
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Control register, unlock procedure and sequencer
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         wen_r <= 1'b0;
         mode_r <= 3'h0;
         unlk_r <= 1'b0;
         wt_r <= 1'b0;
         rden_r <= 1'b0;
         rd_r <= 1'b0;
         buffer_clear_start_r <= 1'b0;
         st_r <= ST_IDLE;
         idx_r <= 6'h00;
         page_r <= 9'h000;
         pat_r <= 3'h0;
         tmo_r <= 5'h00;
         fl_req_o <= 1'b0;
         fl_op_o <= `IFPC_FL_WRITE;
         fl_addr_o <= 15'h0000;
         fl_wdata_o <= 16'h0000;
         cpu_hold_o <= 1'b0;
      end else begin
         if (ctrl_wr) begin // Software side of the control register
            mode_r <= new_mode; // RQ9
            unlk_r <= bus_wdata_i[`IFPC_B_UNLK];
            rden_r <= bus_wdata_i[`IFPC_B_RDEN]; // RQ14
            if (!bus_wdata_i[`IFPC_B_WEN]) begin // Software may only clear the status bit
               wen_r <= 1'b0; // RQ6 RQ7
            end
            if (bus_wdata_i[`IFPC_B_WT] && wen_r && (st_r == ST_IDLE) // Start needs unlocked flash
                && ((new_mode == `IFPC_OP_WRITE) || (new_mode == `IFPC_OP_ERASE))) begin
               wt_r <= 1'b1; // RQ12 RQ17
            end
            if (bus_wdata_i[`IFPC_B_RD] && bus_wdata_i[`IFPC_B_RDEN] && (st_r == ST_IDLE) // Read enable set
                && (new_mode == `IFPC_OP_READ)) begin
               rd_r <= 1'b1; // RQ13 RQ14
            end
         end
         if (wr_hit(`IFPC_ADDR_BUFCLR) && bus_wdata_i[`IFPC_B_BUFFER_CLEAR_START]) begin
            buffer_clear_start_r <= 1'b1; // RQ21
         end
         // Unlock progress: pattern step and sub clock timeout
         if (unlk_act) begin
            if (sub_tick) begin
               tmo_r <= tmo_r + 5'h01; // RQ19
            end
            if (pat_wr && pat_ok) begin
               pat_r <= pat_r + 3'h1; // RQ19
            end
         end else begin
            pat_r <= 3'h0;
            tmo_r <= 5'h00;
         end
         if (unlk_pass) begin // Enable self-clears; hardware set of status wins
            unlk_r <= 1'b0;
            wen_r <= 1'b1; // RQ8 RQ11
         end else if (unlk_fail) begin
            unlk_r <= 1'b0; // RQ19
         end
         case (st_r) // Sequencer
            ST_IDLE: begin
               idx_r <= 6'h00;
               page_r <= far_r[14:6];
               if (wt_r && wen_r && (mode_r == `IFPC_OP_ERASE)) begin // One request wipes the page
                  st_r <= ST_ERASE;
                  fl_req_o <= 1'b1;
                  fl_op_o <= `IFPC_FL_ERASE;
                  fl_addr_o <= {far_r[14:6], 6'h00}; // RQ1
                  cpu_hold_o <= 1'b1;
               end else if (wt_r && wen_r && (mode_r == `IFPC_OP_WRITE)) begin
                  st_r <= ST_WRITE;
                  fl_req_o <= 1'b1;
                  fl_op_o <= `IFPC_FL_WRITE;
                  fl_addr_o <= {far_r[14:6], 6'h00}; // RQ2
                  fl_wdata_o <= wbuf_r[0];
                  cpu_hold_o <= 1'b1;
               end else if (wt_r) begin // Lost enable or mode before start: drop it
                  wt_r <= 1'b0; // RQ17
               end else if (rd_r && rden_r && (mode_r == `IFPC_OP_READ)) begin
                  st_r <= ST_READ;
                  fl_req_o <= 1'b1;
                  fl_op_o <= `IFPC_FL_READ;
                  fl_addr_o <= far_r; // RQ3
                  cpu_hold_o <= 1'b1;
               end else if (rd_r) begin
                  rd_r <= 1'b0; // RQ14
               end else if (buffer_clear_start_r) begin
                  st_r <= ST_CLEAR;
               end
            end
            ST_ERASE, ST_READ: begin
               if (fl_ack_i) begin // Erase and single-word read end on one ack
                  fl_req_o <= 1'b0;
                  wt_r <= 1'b0; // RQ12
                  rd_r <= 1'b0; // RQ13
                  cpu_hold_o <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (last_ack) begin // Step through all 64 buffered words
                  fl_req_o <= 1'b0;
                  wt_r <= 1'b0; // RQ12
                  cpu_hold_o <= 1'b0;
                  st_r <= ST_IDLE;
               end else if (fl_ack_i) begin
                  idx_r <= idx_r + 6'h01;
                  fl_addr_o <= {page_r, idx_r + 6'h01}; // RQ2
                  fl_wdata_o <= wbuf_r[idx_r + 6'h01];
               end
            end
            ST_CLEAR: begin
               idx_r <= idx_r + 6'h01;
               if (clr_done) begin
                  buffer_clear_start_r <= wr_hit(`IFPC_ADDR_BUFCLR) && bus_wdata_i[`IFPC_B_BUFFER_CLEAR_START]; // RQ21 new set wins
                  st_r <= ST_IDLE;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Register read port, answered one cycle after the strobe
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         bus_rdata_o <= `IFPC_BYTE_RST;
      end else if (bus_rd_i) begin
         if (!in_range) begin
            bus_rdata_o <= `IFPC_BYTE_RST;
         end else if (bus_addr_i >= `IFPC_ADDR_DATA0) begin
            bus_rdata_o <= fd_r[fd_idx];
         end else begin
            case (bus_addr_i)
               `IFPC_ADDR_CTRL: bus_rdata_o <= {wen_r, mode_r, unlk_r, wt_r, rden_r, rd_r};
               `IFPC_ADDR_RSTKEY: bus_rdata_o <= key_r;
               `IFPC_ADDR_BUFCLR: bus_rdata_o <= {7'h00, buffer_clear_start_r};
               `IFPC_ADDR_FLASH_ADDR_LOW: bus_rdata_o <= far_r[7:0];
               `IFPC_ADDR_FLASH_ADDR_HIGH: bus_rdata_o <= {1'b0, far_r[14:8]};
               default: bus_rdata_o <= `IFPC_BYTE_RST;
            endcase
         end
      end
   end
   wire unused_ok = &{1'b1, fd_off[7:3]}; // Unused upper bits of the data offset
endmodule
`default_nettype wire

// ===== rtl/ifpc_regs.vh
`ifndef IFPC_REGS_VH
`define IFPC_REGS_VH

// Register sector and byte addresses
`define IFPC_SECTOR 8'h01
`define IFPC_ADDR_FIRST 8'h43
`define IFPC_ADDR_LAST 8'h4F
`define IFPC_ADDR_CTRL 8'h43
`define IFPC_ADDR_RSTKEY 8'h44
`define IFPC_ADDR_BUFCLR 8'h45
`define IFPC_ADDR_FLASH_ADDR_LOW 8'h46
`define IFPC_ADDR_FLASH_ADDR_HIGH 8'h47
`define IFPC_ADDR_DATA0 8'h48

// Control and buffer clear register bit positions
`define IFPC_B_WEN 7
`define IFPC_B_MODE_HI 6
`define IFPC_B_MODE_LO 4
`define IFPC_B_UNLK 3
`define IFPC_B_WT 2
`define IFPC_B_RDEN 1
`define IFPC_B_RD 0
`define IFPC_B_BUFFER_CLEAR_START 0

// Operation select codes
`define IFPC_OP_WRITE 3'h0
`define IFPC_OP_ERASE 3'h1
`define IFPC_OP_READ 3'h3
`define IFPC_OP_UNLOCK 3'h6

// Flash port operation codes
`define IFPC_FL_WRITE 2'h0
`define IFPC_FL_ERASE 2'h1
`define IFPC_FL_READ 2'h2

// Reset values and keys
`define IFPC_BYTE_RST 8'h00
`define IFPC_CHIP_RST_KEY 8'h55

// Unlock pattern, in write order
`define IFPC_PAT0 8'h00
`define IFPC_PAT1 8'h04
`define IFPC_PAT2 8'h0D
`define IFPC_PAT3 8'h09
`define IFPC_PAT4 8'hC3
`define IFPC_PAT5 8'h40
`define IFPC_PAT_LAST 3'h5
`define IFPC_PAT_BASE 3'h2

// Page geometry: 64 words per page and per write
`define IFPC_PAGE_WORDS 64
`define IFPC_IDX_LAST 6'h3F

// Unlock timeout, counted in sub clock periods
`define IFPC_UNLOCK_TIMEOUT_US 300
`define IFPC_FSUB_HZ 32768
`define IFPC_UNLOCK_TICKS ((`IFPC_UNLOCK_TIMEOUT_US * `IFPC_FSUB_HZ) / 1000000)

`endif

// ===== dv/ifpc_flash_seq_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifpc_regs.vh"
module ifpc_flash_seq_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [7:0] bus_sector_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic [7:0] bus_rdata_o,
   // Flash port
   input wire logic fl_req_o,
   input wire logic [1:0] fl_op_o,
   input wire logic [14:0] fl_addr_o,
   input wire logic fl_ack_i,
   // System effects and pads
   input wire logic cpu_hold_o,
   input wire logic chip_rst_o,
   input wire logic prog_serial_data_o,
   input wire logic prog_serial_data_oe_o,
   input wire logic prog_serial_clock_i,
   input wire logic icp_clock_o,
   input wire logic icp_tx_data_i,
   input wire logic icp_tx_en_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Control write while no transfer runs
   wire logic ctrl_go = bus_wr_i && bus_sector_i == `IFPC_SECTOR && bus_addr_i == `IFPC_ADDR_CTRL &&
      !cpu_hold_o && !fl_req_o;
   // Reset key write
   wire logic key_go = bus_wr_i && bus_sector_i == `IFPC_SECTOR && bus_addr_i == `IFPC_ADDR_RSTKEY &&
      bus_wdata_i == `IFPC_CHIP_RST_KEY;
   logic [6:0] wcnt_r; // Words acknowledged in this burst
   ///////////////////////////////////////////////////////////////////////////
   // Count write words, cleared whenever the request drops
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !fl_req_o) begin
         wcnt_r <= 7'h00;
      end else if (fl_ack_i && fl_op_o == `IFPC_FL_WRITE) begin
         wcnt_r <= wcnt_r + 7'h01;
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   a_read_start: assert property (ctrl_go && bus_wdata_i[6:4] == `IFPC_OP_READ && bus_wdata_i[1:0] == 2'h3
      |-> ##2 fl_req_o && fl_op_o == `IFPC_FL_READ && cpu_hold_o) else $error("read start not served");
   a_read_gated: assert property (ctrl_go && bus_wdata_i[1:0] == 2'h1 |-> ##1 (!fl_req_o) [*2])
      else $error("read ran with read enable low");
   a_req_hold: assert property (fl_req_o && !fl_ack_i |=> fl_req_o && $stable(fl_op_o) && $stable(fl_addr_o))
      else $error("flash request changed before ack");
   a_erase_base: assert property (fl_req_o && fl_op_o == `IFPC_FL_ERASE |-> fl_addr_o[5:0] == 6'h00)
      else $error("erase address not page aligned");
   a_single_word: assert property (fl_req_o && fl_ack_i && fl_op_o != `IFPC_FL_WRITE
      |=> !fl_req_o && !cpu_hold_o) else $error("read or erase did not end on ack");
   a_write_count: assert property (fl_req_o && fl_op_o == `IFPC_FL_WRITE |-> wcnt_r < 7'h40)
      else $error("more than 64 words written");
   a_chip_reset: assert property (key_go |=> chip_rst_o ##1 !chip_rst_o)
      else $error("reset key gave no single pulse");
   a_sector_miss: assert property (bus_rd_i && bus_sector_i != `IFPC_SECTOR |=> bus_rdata_o == 8'h00)
      else $error("read outside sector returned data");
   a_pad_drive: assert property (icp_tx_en_i |=> prog_serial_data_oe_o &&
      prog_serial_data_o == $past(icp_tx_data_i)) else $error("pad drive not copied");
   a_clock_pass: assert property ($rose(prog_serial_clock_i) |-> ##[1:6] icp_clock_o)
      else $error("programming clock not passed on");
endmodule
bind ifpc_flash_seq ifpc_flash_seq_chk u_chk (.clk_i, .nrst_i, .bus_sector_i, .bus_addr_i, .bus_wr_i,
   .bus_rd_i, .bus_wdata_i, .bus_rdata_o, .fl_req_o, .fl_op_o, .fl_addr_o, .fl_ack_i, .cpu_hold_o,
   .chip_rst_o, .prog_serial_data_o, .prog_serial_data_oe_o, .prog_serial_clock_i, .icp_clock_o,
   .icp_tx_data_i, .icp_tx_en_i);
`default_nettype wire

// ===== dv/test_in_app_flash_program_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifpc_regs.vh"
module test_in_app_flash_program_ctrl;
   // Stimulus
   logic clk_i = 1'b0, nrst_i = 1'b0, bus_wr_i = 1'b0, bus_rd_i = 1'b0, fl_ack_i = 1'b0, sub_clk_i = 1'b0;
   logic pad_drv = 1'b0, prog_serial_clock_i = 1'b0, icp_tx_data_i = 1'b0, icp_tx_en_i = 1'b0;
   logic [7:0] bus_sector_i = 8'h00, bus_addr_i = 8'h00, bus_wdata_i = 8'h00;
   logic [15:0] fl_rdata_i = 16'h0000;
   // Design outputs
   logic [7:0] bus_rdata_o;
   logic fl_req_o, cpu_hold_o, chip_rst_o, prog_serial_data_o, prog_serial_data_oe_o, icp_data_o, icp_clock_o;
   logic [1:0] fl_op_o;
   logic [14:0] fl_addr_o;
   logic [15:0] fl_wdata_o;
   // Shared pad level
   wire logic prog_serial_data_i = prog_serial_data_oe_o ? prog_serial_data_o : pad_drv;
   // Flash array and bookkeeping
   logic [15:0] mem [0:32767];
   logic [7:0] rd;
   logic [1:0] last_op;
   logic [14:0] last_addr;
   int miscompares = 0, num_checks = 0, cyc = 0, acks = 0, pulses = 0, ack_wait = 0, n;
   ifpc_flash_seq u_dut (.clk_i, .nrst_i, .bus_sector_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
      .bus_rdata_o, .fl_req_o, .fl_op_o, .fl_addr_o, .fl_wdata_o, .fl_ack_i, .fl_rdata_i, .sub_clk_i,
      .cpu_hold_o, .chip_rst_o, .prog_serial_data_i, .prog_serial_data_o, .prog_serial_data_oe_o,
      .prog_serial_clock_i, .icp_data_o, .icp_clock_o, .icp_tx_data_i, .icp_tx_en_i);
   always #2 clk_i = ~clk_i;
   always #20 sub_clk_i = ~sub_clk_i; // Fast sub clock keeps the unlock timeout short
   ///////////////////////////////////////////////////////////////////////////
   // Ack each flash request three cycles in
   always @(negedge clk_i) begin
      fl_ack_i <= 1'b0;
      if (fl_req_o && !fl_ack_i) begin
         ack_wait <= ack_wait + 1;
         if (ack_wait == 2) begin
            fl_ack_i <= 1'b1;
            fl_rdata_i <= mem[fl_addr_o];
            ack_wait <= 0;
         end
      end
   end
   // Array effects, pulse count and hang limit
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (chip_rst_o) pulses <= pulses + 1;
      if (fl_req_o && fl_ack_i) begin
         acks <= acks + 1;
         last_op <= fl_op_o;
         last_addr <= fl_addr_o;
         if (fl_op_o == `IFPC_FL_WRITE) mem[fl_addr_o] <= fl_wdata_o;
         if (fl_op_o == `IFPC_FL_ERASE) for (int j = 0; j < 64; j++) mem[{fl_addr_o[14:6], 6'(j)}] <= 16'hFFFF;
      end
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One register write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] s = 8'h01);
      @(negedge clk_i);
      bus_sector_i = s;
      bus_addr_i = a;
      bus_wdata_i = d;
      bus_wr_i = 1'b1;
      @(negedge clk_i);
      bus_wr_i = 1'b0;
   endtask
   // One register read cycle and compare
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] s = 8'h01);
      @(negedge clk_i);
      bus_sector_i = s;
      bus_addr_i = a;
      bus_rd_i = 1'b1;
      @(negedge clk_i);
      bus_rd_i = 1'b0;
      chk(what, {8'h00, bus_rdata_o}, {8'h00, exp});
   endtask
   // Bounded wait for the flash transfer to end
   task automatic wait_idle;
      int k;
      k = 0;
      repeat (2) @(negedge clk_i);
      while ((fl_req_o || cpu_hold_o) && k < 1000) begin
         @(negedge clk_i);
         k++;
      end
      chk("flash idle", {15'h0000, fl_req_o}, 16'h0000);
   endtask
   // Unlock attempt with a delay and a corrupt mask on one byte
   task automatic unlock(input logic [7:0] bad, input int gap);
      logic [7:0] pat [6];
      pat = '{`IFPC_PAT0, `IFPC_PAT1, `IFPC_PAT2, `IFPC_PAT3, `IFPC_PAT4, `IFPC_PAT5};
      wr(`IFPC_ADDR_CTRL, 8'h68);
      repeat (gap) @(negedge clk_i);
      for (int i = 0; i < 6; i++) wr(8'h4A + 8'(i), pat[i] ^ (i == 4 ? bad : 8'h00));
   endtask
   ///////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int a = 8'h43; a <= 8'h4F; a++) rchk("reset value", 8'(a), 8'h00);
      rchk("other sector", `IFPC_ADDR_CTRL, 8'h00, 8'h02);
      wr(`IFPC_ADDR_FLASH_ADDR_LOW, 8'h3C, 8'h02);
      rchk("miss write", `IFPC_ADDR_FLASH_ADDR_LOW, 8'h00);
   endtask
   task automatic t_locked;
      n = acks;
      wr(`IFPC_ADDR_CTRL, 8'h84);
      rchk("status set by write", `IFPC_ADDR_CTRL, 8'h00);
      wr(`IFPC_ADDR_CTRL, 8'h14);
      repeat (6) @(negedge clk_i);
      rchk("locked erase", `IFPC_ADDR_CTRL, 8'h10);
      chk("locked acks", 16'(acks), 16'(n));
   endtask
   task automatic t_read;
      logic [15:0] w;
      w = 16'h0105 ^ 16'hA5C3;
      wr(`IFPC_ADDR_FLASH_ADDR_LOW, 8'h05);
      wr(`IFPC_ADDR_FLASH_ADDR_HIGH, 8'h01);
      n = acks;
      wr(`IFPC_ADDR_CTRL, 8'h33);
      wait_idle();
      chk("read acks", 16'(acks), 16'(n + 1));
      chk("read op", {14'h0000, last_op}, {14'h0000, `IFPC_FL_READ});
      chk("read addr", {1'b0, last_addr}, 16'h0105);
      rchk("read done", `IFPC_ADDR_CTRL, 8'h32);
      rchk("read low", `IFPC_ADDR_DATA0, w[7:0]);
      rchk("read high", `IFPC_ADDR_DATA0 + 8'h01, w[15:8]);
      wr(`IFPC_ADDR_CTRL, 8'h31);
      repeat (6) @(negedge clk_i);
      chk("gated acks", 16'(acks), 16'(n + 1));
      rchk("gated ctrl", `IFPC_ADDR_CTRL, 8'h30);
   endtask
   task automatic t_unlock;
      unlock(8'h00, 150);
      rchk("late pattern", `IFPC_ADDR_CTRL, 8'h60);
      unlock(8'h01, 0);
      rchk("wrong pattern", `IFPC_ADDR_CTRL, 8'h60);
      unlock(8'h00, 0);
      rchk("unlocked", `IFPC_ADDR_CTRL, 8'hE0);
   endtask
   task automatic t_program;
      wr(`IFPC_ADDR_BUFCLR, 8'h01);
      rchk("clear running", `IFPC_ADDR_BUFCLR, 8'h01);
      repeat (70) @(negedge clk_i);
      rchk("clear done", `IFPC_ADDR_BUFCLR, 8'h00);
      wr(`IFPC_ADDR_FLASH_ADDR_LOW, 8'h47);
      wr(`IFPC_ADDR_FLASH_ADDR_HIGH, 8'h02);
      n = acks;
      wr(`IFPC_ADDR_CTRL, 8'h94);
      wait_idle();
      chk("erase acks", 16'(acks), 16'(n + 1));
      chk("erase addr", {1'b0, last_addr}, 16'h0240);
      rchk("erase done", `IFPC_ADDR_CTRL, 8'h90);
      wr(`IFPC_ADDR_FLASH_ADDR_LOW, 8'h40);
      for (int i = 0; i < 64; i++) begin
         wr(`IFPC_ADDR_DATA0, 8'(i));
         wr(`IFPC_ADDR_DATA0 + 8'h01, ~8'(i));
      end
      rchk("addr bumped low", `IFPC_ADDR_FLASH_ADDR_LOW, 8'h80);
      rchk("addr bumped high", `IFPC_ADDR_FLASH_ADDR_HIGH, 8'h02);
      wr(`IFPC_ADDR_FLASH_ADDR_LOW, 8'h40);
      n = acks;
      wr(`IFPC_ADDR_CTRL, 8'h84);
      wait_idle();
      chk("write acks", 16'(acks), 16'(n + 64));
      for (int i = 0; i < 64; i++) chk("written word", mem[15'h0240 + 15'(i)], {~8'(i), 8'(i)});
      rchk("write done", `IFPC_ADDR_CTRL, 8'h80);
   endtask
   task automatic t_disable;
      wr(`IFPC_ADDR_CTRL, 8'h00);
      rchk("disabled", `IFPC_ADDR_CTRL, 8'h00);
      n = acks;
      wr(`IFPC_ADDR_CTRL, 8'h14);
      repeat (6) @(negedge clk_i);
      chk("disabled acks", 16'(acks), 16'(n));
   endtask
   task automatic t_pads;
      @(negedge clk_i);
      icp_tx_en_i = 1'b1;
      icp_tx_data_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("pad drive", {14'h0000, prog_serial_data_oe_o, prog_serial_data_o}, 16'h0003);
      icp_tx_en_i = 1'b0;
      pad_drv = 1'b1;
      prog_serial_clock_i = 1'b1;
      repeat (8) @(negedge clk_i);
      chk("pad in", {14'h0000, icp_data_o, icp_clock_o}, 16'h0003);
      pad_drv = 1'b0;
      prog_serial_clock_i = 1'b0;
      repeat (8) @(negedge clk_i);
      chk("pad idle", {14'h0000, icp_data_o, icp_clock_o}, 16'h0000);
   endtask
   task automatic t_chip_reset;
      wr(`IFPC_ADDR_RSTKEY, 8'h54);
      wr(`IFPC_ADDR_RSTKEY, 8'h55);
      repeat (3) @(negedge clk_i);
      chk("reset pulses", 16'(pulses), 16'h0001);
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ///////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 16'(i) ^ 16'hA5C3;
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      t_reset();
      t_locked();
      t_read();
      t_unlock();
      t_program();
      t_disable();
      t_pads();
      t_chip_reset();
      stop_test();
   end
endmodule
`default_nettype wire
